// file: irq_gate_pkg.sv
package irq_gate_pkg;
  // flag register bit positions
  localparam int unsigned FLAG_W = 16;
  localparam int unsigned BIT_IEN = 6;
  localparam int unsigned BIT_STKSEL = 7;
  localparam int unsigned BIT_RSVD = 11;
  localparam int unsigned BIT_PPL_LO = 12;
  localparam int unsigned PPL_W = 3;
  // reset values
  localparam logic IEN_RST = 1'b0;
  localparam logic STKSEL_RST = 1'b0;
  localparam logic [2:0] PPL_RST = 3'h0;
  // memory map figures
  localparam logic [19:0] VEC_BASE = 20'h0FFDC;
  localparam logic [19:0] VEC_LAST = 20'h0FFFF;
  localparam logic [19:0] RAM_BASE = 20'h00400;
  localparam logic [19:0] STACK_RST = 20'h00800;
  localparam logic [5:0] SWI_MAX_FLAGCLR = 6'h1F;
  localparam int unsigned ENTRY_BYTES = 4;
endpackage

// file: irq_gate.sv
`timescale 1ns/1ps
// Functional notes
// - enable flag zero blocks maskable requests
// - acceptance clears the interrupt enable flag
// - stack select picks interrupt or user pointer
// - hardware accept or swi 0-31 clears select
// - priority level is three bits, 0..7
// - accept only priority above current level
// - reserved flag bit reads zero, write zero
// - vector table spans 0FFDCh to 0FFFFh
// - state saved on RAM stack from 00400h
module irq_gate
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // hardware request
  input wire logic irq_req_i,
  input wire logic [2:0] irq_prio_i,
  input wire logic [2:0] irq_vec_i,
  // software interrupt instruction
  input wire logic swi_exec_i,
  input wire logic [5:0] swi_num_i,
  // flag writes from sequencer
  input wire logic flag_we_i,
  input wire logic [15:0] flag_wdata_i,
  // stack pointers held by core
  input wire logic [19:0] interrupt_stack_pointer_i,
  input wire logic [19:0] user_stack_pointer_i,
  // outputs
  output logic irq_ack_o,
  output logic [19:0] active_sp_o,
  output logic [19:0] vec_addr_o,
  output logic vec_fetch_o,
  output logic save_ok_o,
  output logic [15:0] flag_o,
  output logic [2:0] processor_priority_level_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_RUN} seq_t;
  typedef struct packed {
    seq_t st;
    logic ien;
    logic stksel;
    logic [2:0] ppl;
    logic ack;
    logic fetch;
    logic [19:0] vaddr;
  } state_t;
  // registered state and its next value
  state_t q, d;
  // combinational decisions taken every cycle
  logic accept;
  logic swi_clr;

  // vector entry address from request index
  // entries sit back to back, one routine address each
  function automatic logic [19:0] vec_entry(input logic [2:0] idx);
    vec_entry = irq_gate_pkg::VEC_BASE + 20'(idx) * 20'(irq_gate_pkg::ENTRY_BYTES);
  endfunction

  // acceptance decision
  assign accept = irq_req_i && q.ien && (irq_prio_i > q.ppl) && (q.st == ST_IDLE);
  assign swi_clr = swi_exec_i && (swi_num_i <= irq_gate_pkg::SWI_MAX_FLAGCLR);

  // next state
  always_comb
  begin
    d = q;
    d.ack = 1'b0;
    d.fetch = 1'b0;
    if (flag_we_i)
    begin
      d.ien = flag_wdata_i[irq_gate_pkg::BIT_IEN];
      d.stksel = flag_wdata_i[irq_gate_pkg::BIT_STKSEL];
      d.ppl = flag_wdata_i[irq_gate_pkg::BIT_PPL_LO +: irq_gate_pkg::PPL_W];
    end
    if (swi_clr)
      d.stksel = 1'b0;
    case (q.st)
      ST_IDLE:
      begin
        if (accept)
        begin
          d.ien = 1'b0;
          d.stksel = 1'b0;
          d.ppl = irq_prio_i;
          d.ack = 1'b1;
          d.vaddr = vec_entry(irq_vec_i);
          d.st = ST_FETCH;
        end
      end
      // new requests are held off while the vector is read
      ST_FETCH:
      begin
        d.fetch = 1'b1;
        d.st = ST_RUN;
      end
      // one settling cycle before the next acceptance
      ST_RUN:
        d.st = ST_IDLE;
      default:
        d.st = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      q.st <= ST_IDLE;
      q.ien <= irq_gate_pkg::IEN_RST;
      q.stksel <= irq_gate_pkg::STKSEL_RST;
      q.ppl <= irq_gate_pkg::PPL_RST;
      q.ack <= 1'b0;
      q.fetch <= 1'b0;
      q.vaddr <= irq_gate_pkg::VEC_BASE;
    end
    else
      q <= d;
  end

  // outputs; reserved bit reads zero
  assign irq_ack_o = q.ack;
  assign vec_fetch_o = q.fetch;
  assign vec_addr_o = q.vaddr;
  assign active_sp_o = q.stksel ? user_stack_pointer_i : interrupt_stack_pointer_i;
  assign save_ok_o = (active_sp_o > irq_gate_pkg::RAM_BASE);
  assign processor_priority_level_o = q.ppl;
  always_comb
  begin
    flag_o = '0;
    flag_o[irq_gate_pkg::BIT_IEN] = q.ien;
    flag_o[irq_gate_pkg::BIT_STKSEL] = q.stksel;
    flag_o[irq_gate_pkg::BIT_RSVD] = 1'b0;
    flag_o[irq_gate_pkg::BIT_PPL_LO +: irq_gate_pkg::PPL_W] = q.ppl;
  end

  // checks
  a_mask_blocks: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !q.ien |=> !irq_ack_o) else $error("ack with enable flag clear");
  a_ack_clears_en: assert property (@(posedge core_clk_i) disable iff (srst_i)
    accept |=> !q.ien) else $error("enable flag not cleared");
  a_sp_select: assert property (@(posedge core_clk_i) disable iff (srst_i)
    q.stksel |-> active_sp_o == user_stack_pointer_i) else $error("wrong stack");
  a_ack_clears_sel: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (accept || swi_clr) |=> !q.stksel) else $error("select not cleared");
  a_prio_strict: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (irq_req_i && irq_prio_i <= q.ppl) |=> !irq_ack_o) else $error("low prio taken");
  a_vec_range: assert property (@(posedge core_clk_i) disable iff (srst_i)
    vec_fetch_o |-> (vec_addr_o >= irq_gate_pkg::VEC_BASE && vec_addr_o <= irq_gate_pkg::VEC_LAST))
    else $error("vector out of table");
  a_fetch_follows: assert property (@(posedge core_clk_i) disable iff (srst_i)
    irq_ack_o |=> vec_fetch_o ##1 !vec_fetch_o) else $error("no vector fetch");
  a_rsvd_zero: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !flag_o[irq_gate_pkg::BIT_RSVD]) else $error("reserved bit set");
  c_accept: cover property (@(posedge core_clk_i) disable iff (srst_i) irq_ack_o ##1 vec_fetch_o);
  c_blocked: cover property (@(posedge core_clk_i) disable iff (srst_i) irq_req_i && !q.ien);
  c_swi: cover property (@(posedge core_clk_i) disable iff (srst_i) swi_clr && q.stksel);
  // request refused for a level at or under the current one
  c_low_prio: cover property (@(posedge core_clk_i) disable iff (srst_i)
    irq_req_i && q.ien && irq_prio_i <= q.ppl);

  // extra guards on the acceptance path
  // accept loads the request's level into the flags
  a_level_load: assert property (@(posedge core_clk_i) disable iff (srst_i)
    accept |=> processor_priority_level_o == $past(irq_prio_i))
    else $error("level not taken from request");
  // an acknowledge needs the enable flag set one cycle before
  a_ack_needs_en: assert property (@(posedge core_clk_i) disable iff (srst_i)
    irq_ack_o |-> $past(q.ien))
    else $error("ack without enable flag");
  // an acknowledge needs a strictly higher request level
  a_ack_prio: assert property (@(posedge core_clk_i) disable iff (srst_i)
    irq_ack_o |-> $past(irq_prio_i > q.ppl))
    else $error("ack at or under current level");
  // no acceptance while the vector sequence runs
  a_busy_refuse: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (q.st != ST_IDLE) |=> !irq_ack_o)
    else $error("ack while sequencer busy");
  // acknowledge stands one cycle only
  a_ack_single: assert property (@(posedge core_clk_i) disable iff (srst_i)
    irq_ack_o |=> !irq_ack_o)
    else $error("ack longer than one cycle");
  // clear select picks the interrupt pointer
  a_sp_interrupt: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !q.stksel |-> active_sp_o == interrupt_stack_pointer_i)
    else $error("interrupt stack not selected");

  // vector fetch follows an acknowledge
  a_fetch_src: assert property (@(posedge core_clk_i) disable iff (srst_i)
    vec_fetch_o |-> $past(irq_ack_o))
    else $error("fetch without ack");
  // entries are whole words inside the table
  a_vec_align: assert property (@(posedge core_clk_i) disable iff (srst_i)
    vec_fetch_o |-> vec_addr_o[1:0] == 2'h0)
    else $error("vector entry misaligned");
  // fetch pulse marks entry into the run state
  a_fetch_state: assert property (@(posedge core_clk_i) disable iff (srst_i)
    vec_fetch_o |-> q.st == ST_RUN)
    else $error("fetch outside run state");
  // acknowledge shows the enable and select flags already cleared
  a_ack_sel_clr: assert property (@(posedge core_clk_i) disable iff (srst_i)
    irq_ack_o |-> !flag_o[irq_gate_pkg::BIT_STKSEL])
    else $error("select set at ack");
  a_ack_en_clr: assert property (@(posedge core_clk_i) disable iff (srst_i)
    irq_ack_o |-> !flag_o[irq_gate_pkg::BIT_IEN])
    else $error("enable set at ack");

  // a plain flag write lands when no acceptance competes
  a_flag_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (flag_we_i && !accept) |=> q.ien == $past(flag_wdata_i[irq_gate_pkg::BIT_IEN]))
    else $error("enable write lost");
  a_ppl_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (flag_we_i && !accept) |=> processor_priority_level_o == $past(flag_wdata_i[14:12]))
    else $error("level write lost");
  // request arriving while the sequencer is busy
  c_busy: cover property (@(posedge core_clk_i) disable iff (srst_i)
    irq_req_i && q.st != ST_IDLE);
endmodule

// file: irq_src_model.sv
`timescale 1ns/1ps
module irq_src_model
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // request control and acceptance
  input wire logic fire_i,
  input wire logic ack_i,
  // request line
  output logic irq_req_o
);
  logic acked_q;
  // level request held until accepted, dropped when withdrawn
  assign irq_req_o = fire_i & ~acked_q;
  always_ff @(posedge core_clk_i)
    acked_q <= !srst_i && fire_i && (acked_q || ack_i);
endmodule

// file: cpu_interrupt_flag_gating_tb_top.sv
`timescale 1ns/1ps
module cpu_interrupt_flag_gating_tb_top;
  logic clk = 0, srst = 1, we = 0, swi = 0, fire = 0, req, ack, fet, ok, en, sel;
  logic [2:0] pr = 0, vc = 0, lvl, lv;
  logic [5:0] sn = 0;
  logic [15:0] wd = 0, fl;
  logic [19:0] interrupt_stack_pointer = 0, user_stack_pointer = 0, sp, va;
  int error_cnt = 0, compares = 0, cyc = 0;
  initial forever #2.5 clk = ~clk;
  irq_src_model i_irq_src_model(.core_clk_i(clk), .srst_i(srst), .fire_i(fire), .ack_i(ack),
    .irq_req_o(req));
  irq_gate i_irq_gate(.core_clk_i(clk), .srst_i(srst), .irq_req_i(req), .irq_prio_i(pr),
    .irq_vec_i(vc), .swi_exec_i(swi), .swi_num_i(sn), .flag_we_i(we), .flag_wdata_i(wd),
    .interrupt_stack_pointer_i(interrupt_stack_pointer), .user_stack_pointer_i(user_stack_pointer), .irq_ack_o(ack),
    .active_sp_o(sp), .vec_addr_o(va), .vec_fetch_o(fet), .save_ok_o(ok), .flag_o(fl),
    .processor_priority_level_o(lvl));
  task automatic chk(input logic [19:0] e, input logic [19:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge clk)
    if (++cyc > 5000)
    begin
      error_cnt++;
      complete_run();
    end
  // random flag loads, requests and software interrupts
  initial
  begin
    void'($urandom(4294));
    repeat (6) @(posedge clk);
    #1 srst = 0;
    chk(20'(fl), 20'h0);
    chk(20'(lvl), 20'h0);
    chk(va, irq_gate_pkg::VEC_BASE);
    for (int i = 0; i < 80; i++)
    begin
      {en, sel, lv} = 5'($urandom);
      interrupt_stack_pointer = 20'($urandom);
      user_stack_pointer = (i % 4) ? 20'($urandom) : irq_gate_pkg::RAM_BASE;
      we = 1;
      wd = {1'b0, lv, 4'h0, sel, en, 6'h00};
      @(posedge clk);
      #1 we = 0;
      chk(sp, sel ? user_stack_pointer : interrupt_stack_pointer);
      chk(20'(ok), 20'((sel ? user_stack_pointer : interrupt_stack_pointer) > irq_gate_pkg::RAM_BASE));
      pr = (i % 2) ? 3'($urandom) : lv + 3'h1;
      vc = 3'($urandom);
      fire = 1;
      @(posedge clk);
      #1 fire = 0;
      chk(20'(ack), 20'(en && pr > lv));
      if (en && pr > lv)
      begin
        chk(20'(fl[7:6]), 20'h0);
        chk(20'(lvl), 20'(pr));
        chk(va, irq_gate_pkg::VEC_BASE + 20'(vc) * 20'h4);
        @(posedge clk);
        #1 chk(20'(fet), 20'h1);
      end
      else
      begin
        sn = 6'($urandom);
        swi = 1;
        @(posedge clk);
        #1 swi = 0;
        chk(20'(fl[7]), 20'((sn <= 6'h1F) ? 1'b0 : sel));
      end
      repeat (2) @(posedge clk);
      #1;
    end
    complete_run();
  end
endmodule
